// ### common/cep_map.svh
/*
 * constants for the core event prioritizer: level numbers, widths, counts.
 * assumes inclusion by bare name from package and rtl files.
 */
`ifndef CEP_MAP_SVH
`define CEP_MAP_SVH

`define CEP_NUM_LEVELS     16
`define CEP_LVL_W          4
`define CEP_LVL_EMU        4'h0
`define CEP_LVL_RST        4'h1
`define CEP_LVL_NMI        4'h2
`define CEP_LVL_EXC        4'h3
`define CEP_LVL_RSVD       4'h4
`define CEP_LVL_HWERR      4'h5
`define CEP_LVL_TMR        4'h6
`define CEP_LVL_GP_FIRST   4'h7
`define CEP_LVL_GP_LAST    4'hf
`define CEP_NUM_GP         9
`define CEP_ADDR_W         32
`define CEP_IDLE_LVL       5'h10
`define CEP_MASK_RESET     16'h0000
`define CEP_UNMASKABLE     16'h0007

`endif

// ### common/cep_pkg.sv
/*
 * types shared by the core event prioritizer files.
 * assumes cep_map.svh is on the include path.
 */
`include "cep_map.svh"

package cep_pkg;

    // one bit per priority level, bit 0 highest
    typedef logic [`CEP_NUM_LEVELS-1:0] cep_vec_t;

    // dispatch request handed to the core sequencer
    typedef struct packed {
        logic                   valid;    // take strobe, held while a winner stands until take_ack
        logic [`CEP_LVL_W-1:0]  level;    // level being entered
    } cep_take_t;

    // synchroniser state for asynchronous inputs
    typedef struct packed {
        logic [`CEP_NUM_GP+1:0] s1;       // first stage
        logic [`CEP_NUM_GP+1:0] s2;       // second stage
    } cep_sync_t;

endpackage : cep_pkg

// ### rtl/cep_sync.sv
/*
 * two-flop synchroniser for the asynchronous event inputs.
 * assumes single clock ref_clk, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cep_map.svh"

module cep_sync (
    input  wire logic                   ref_clk,   // core clock
    input  wire logic                   reset,     // sync reset
    input  wire logic [`CEP_NUM_GP+1:0] async_in,  // raw levels
    output var  logic [`CEP_NUM_GP+1:0] sync_out   // synchronised
);
    cep_pkg::cep_sync_t st;        // registered state
    cep_pkg::cep_sync_t next_st;   // next state

    // first stage feeds only the second stage
    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;

endmodule : cep_sync
`default_nettype wire

// ### rtl/cep_pick.sv
/*
 * fixed priority picker: lowest set bit of a level vector wins.
 * assumes purely combinational use inside the prioritizer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cep_map.svh"

module cep_pick (
    input  wire logic [`CEP_NUM_LEVELS-1:0] req,    // candidate levels
    output var  logic                       found,  // any candidate
    output var  logic [`CEP_LVL_W-1:0]      level   // winning level
);
    // scan from lowest priority upward so level 0 overwrites last
    always_comb begin
        found = 1'b0;
        level = '0;
        for (int i = `CEP_NUM_LEVELS - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                level = i[`CEP_LVL_W-1:0];
            end
        end
    end

endmodule : cep_pick
`default_nettype wire

// ### rtl/cep_core.sv
/*
 * core event prioritizer: latches dedicated and general-purpose events,
 * masks them, picks the highest priority and nests service routines.
 * assumes the core sequencer pulses take_ack and ret_valid on ref_clk;
 * general-purpose levels arrive already routed by the system router.
 */
// What this block does
// RULE_01: nine general inputs at levels seven to fifteen
// RULE_02: fixed priority, lower number wins, level four reserved
// RULE_03: nested routines, higher priority preempts lower
// RULE_04: highest pending event dispatched first
// RULE_05: software keeps levels fourteen, fifteen for itself; here routed gp_req inputs also raise them
// RULE_06: nmi from watchdog or active-low pin
// RULE_07: exceptions synchronous, taken before instruction completes
// RULE_08: interrupts asynchronous: pins, timers, peripherals, software
// RULE_09: per-level return address register and return
// RULE_10: emulation event enters jtag emulation mode
// RULE_11: reset event resets processor, second priority
// RULE_12: state saved on supervisor stack on entry
// RULE_13: peripherals reach general inputs through the router
// RULE_14: router default mapping, software may remap it
// RULE_15: latch requests, dispatch only above current level
`timescale 1ns/1ps
`default_nettype none
`include "cep_map.svh"

module cep_core (
    input  wire logic                    ref_clk,        // core clock
    input  wire logic                    reset,          // sync reset
    input  wire logic                    emu_req,        // emulation event
    input  wire logic                    core_reset_req, // reset event
    input  wire logic                    nmi_n,          // nmi pin, low
    input  wire logic                    wdog_nmi,       // watchdog nmi
    input  wire logic                    exc_req,        // sync exception
    input  wire logic                    hw_err_req,     // hardware error
    input  wire logic                    timer_req,      // core timer
    input  wire logic [`CEP_NUM_GP-1:0]  gp_req,         // routed levels
    input  wire logic [`CEP_NUM_GP-1:0]  soft_raise,     // software raise
    input  wire logic [`CEP_NUM_LEVELS-1:0] mask,        // 1 = enabled
    input  wire logic [`CEP_ADDR_W-1:0]  cur_pc,         // return address
    input  wire logic                    take_ack,       // core took event
    input  wire logic                    ret_valid,      // return executed
    input  wire logic [`CEP_LVL_W-1:0]   ret_level,      // which return
    output var  logic                    take_valid,     // dispatch request
    output var  logic [`CEP_LVL_W-1:0]   take_level,     // level requested
    output var  logic                    save_state,     // push on stack
    output var  logic                    emu_mode,       // jtag control
    output var  logic                    proc_reset,     // reset pulse
    output var  logic [`CEP_NUM_LEVELS-1:0] pending,     // latched events
    output var  logic [`CEP_NUM_LEVELS-1:0] active,      // nested levels
    output var  logic [`CEP_ADDR_W-1:0]  ret_addr        // selected return
);
    // dispatch handshake states
    typedef enum logic [0:0] {
        CEP_IDLE,
        CEP_OFFER
    } cep_state_t;

    // complete state of the block
    typedef struct packed {
        cep_state_t                 fsm;       // handshake phase
        cep_pkg::cep_vec_t          pend;      // latched requests
        cep_pkg::cep_vec_t          act;       // active routine stack
        logic [`CEP_NUM_GP:0]       gp_prev;   // edge memory: gp + nmi
        cep_pkg::cep_take_t         take;      // offered level
        logic                       save;      // save strobe
        logic                       emulation_event;       // emulation mode
        logic                       prst;      // reset pulse
        logic [`CEP_ADDR_W-1:0]     ra;        // return address out
    } cep_st_t;

    cep_st_t st;         // registered state
    cep_st_t next_st;    // next state

    // return address per level, one register each
    logic [`CEP_ADDR_W-1:0] ret_regs [`CEP_NUM_LEVELS];

    logic [`CEP_NUM_GP+1:0] raw_async;   // pins needing sync
    logic [`CEP_NUM_GP+1:0] synced;      // after two flops
    logic [`CEP_NUM_GP-1:0] gp_s;        // synced general levels
    logic                   nmi_s;       // synced nmi pin, high true
    logic                   wdog_s;      // synced watchdog
    logic [`CEP_NUM_GP:0]   lvl_now;     // current gp + nmi level
    cep_pkg::cep_vec_t      raise;       // new events this cycle
    cep_pkg::cep_vec_t      elig;        // pending and enabled
    cep_pkg::cep_vec_t      above;       // levels above current
    logic                   win_found;   // any eligible winner
    logic [`CEP_LVL_W-1:0]  win_lvl;     // winning level
    logic                   act_found;   // something being serviced
    logic [`CEP_LVL_W-1:0]  act_lvl;     // current service level

    // async sources: general inputs, nmi pin, watchdog
    assign raw_async = {wdog_nmi, ~nmi_n, gp_req};   // [RULE_06] [RULE_08]

    cep_sync u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (raw_async),
        .sync_out (synced)
    );

    assign gp_s    = synced[`CEP_NUM_GP-1:0];
    assign nmi_s   = synced[`CEP_NUM_GP];
    assign wdog_s  = synced[`CEP_NUM_GP+1];
    assign lvl_now = {nmi_s, gp_s};

    // current service level: highest active routine
    cep_pick u_act (
        .req   (st.act),
        .found (act_found),
        .level (act_lvl)
    );

    // winner among eligible requests
    cep_pick u_win (
        .req   (elig),
        .found (win_found),
        .level (win_lvl)
    );

    // build raise vector and eligibility
    always_comb begin
        raise = '0;
        raise[`CEP_LVL_EMU]   = emu_req;                       // [RULE_10]
        raise[`CEP_LVL_RST]   = core_reset_req;                // [RULE_11]
        raise[`CEP_LVL_NMI]   = (nmi_s & ~st.gp_prev[`CEP_NUM_GP])
                              | wdog_s;                        // [RULE_06]
        raise[`CEP_LVL_EXC]   = exc_req;   // sync source, unsynced [RULE_07]
        raise[`CEP_LVL_HWERR] = hw_err_req;
        raise[`CEP_LVL_TMR]   = timer_req;
        // general levels: rising edge of routed input or software raise
        for (int g = 0; g < `CEP_NUM_GP; g++) begin
            raise[g + int'(`CEP_LVL_GP_FIRST)] =
                (gp_s[g] & ~st.gp_prev[g]) | soft_raise[g]; // [RULE_01] [RULE_13]
        end
        raise[`CEP_LVL_RSVD] = 1'b0;                           // [RULE_02]
        // levels strictly above current service level
        above = '0;
        for (int i = 0; i < `CEP_NUM_LEVELS; i++) begin
            above[i] = !act_found || (i < int'(act_lvl));     // [RULE_15] [RULE_03]
        end
        // emulation, reset and nmi ignore the mask
        elig = st.pend & (mask | `CEP_UNMASKABLE) & above;    // [RULE_15]
    end

    // next state
    always_comb begin
        next_st           = st;
        next_st.take.valid = 1'b0;
        next_st.save      = 1'b0;
        next_st.prst      = 1'b0;
        next_st.gp_prev   = lvl_now;
        // latch new events; set wins over clear below
        next_st.pend = st.pend | raise;                        // [RULE_15]
        // return pops that level from the active stack
        if (ret_valid) begin
            next_st.act[ret_level] = 1'b0;                     // [RULE_09] [RULE_03]
            if (ret_level == `CEP_LVL_EMU) begin
                next_st.emulation_event = 1'b0;
            end
        end
        case (st.fsm)
            CEP_IDLE: begin
                if (win_found) begin
                    next_st.take.valid = 1'b1;                 // [RULE_04]
                    next_st.take.level = win_lvl;              // [RULE_02]
                    next_st.fsm        = CEP_OFFER;
                end
            end
            CEP_OFFER: begin
                if (take_ack) begin
                    // entry: clear pending, push level (reset empties the stack), save state
                    next_st.pend[st.take.level] = raise[st.take.level];
                    next_st.act[st.take.level]  = 1'b1;        // [RULE_03]
                    next_st.save = 1'b1;                       // [RULE_12]
                    if (st.take.level == `CEP_LVL_EMU) begin
                        next_st.emulation_event = 1'b1;                    // [RULE_10]
                    end
                    if (st.take.level == `CEP_LVL_RST) begin
                        next_st.prst = 1'b1;                   // [RULE_11]
                        next_st.act  = '0;
                    end
                    next_st.fsm = CEP_IDLE;
                end else if (win_found && win_lvl < st.take.level) begin
                    // higher event arrived: replace the offer
                    next_st.take.valid = 1'b1;                 // [RULE_04]
                    next_st.take.level = win_lvl;
                end else if (win_found) begin
                    // offered level may have been masked: follow the winner
                    next_st.take.valid = 1'b1;                 // [RULE_15]
                    next_st.take.level = win_lvl;
                end else begin
                    next_st.fsm = CEP_IDLE;
                end
            end
            default: begin
                next_st.fsm = CEP_IDLE;
            end
        endcase
        next_st.ra = ret_regs[ret_level];                      // [RULE_09]
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // return address captured per level on entry
    always_ff @(posedge ref_clk) begin
        if (st.fsm == CEP_OFFER && take_ack) begin
            ret_regs[st.take.level] <= cur_pc;                 // [RULE_09]
        end
    end

    assign take_valid = st.take.valid;
    assign take_level = st.take.level;
    assign save_state = st.save;
    assign emu_mode   = st.emulation_event;
    assign proc_reset = st.prst;
    assign pending    = st.pend;
    assign active     = st.act;
    assign ret_addr   = st.ra;

endmodule : cep_core
`default_nettype wire

// ### sim/cep_core_checker.sv
/* checker for cep_core: offer, accept, nesting and return relations.
   assumes binding to cep_core, one clock, sync active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cep_core_checker (
    input wire logic        ref_clk,    // core clock
    input wire logic        reset,      // sync reset
    input wire logic        take_valid, // offer standing
    input wire logic [3:0]  take_level, // offered level
    input wire logic        take_ack,   // core accepted
    input wire logic        save_state, // stack push pulse
    input wire logic        proc_reset, // reset pulse
    input wire logic        ret_valid,  // return executed
    input wire logic [3:0]  ret_level,  // level returned
    input wire logic [15:0] mask,       // level enables
    input wire logic [15:0] pending,    // latched events
    input wire logic [15:0] active      // nested levels
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire acc = take_valid && take_ack;  // offer accepted this edge
    wire nrs = take_level != 4'h1;      // not the reset level

    property p_no_rsvd; take_valid |-> take_level != 4'h4; endproperty
    a_no_rsvd: assert property (p_no_rsvd)
        else $error("reserved level offered");
    property p_save; acc && nrs |=> save_state; endproperty
    a_save: assert property (p_save)
        else $error("no state save after accept");
    property p_pulse; save_state |=> !save_state; endproperty
    a_pulse: assert property (p_pulse)
        else $error("state save longer than one cycle");
    property p_nest; acc && nrs |=> active[$past(take_level)]; endproperty
    a_nest: assert property (p_nest)
        else $error("accepted level not active");
    property p_gap; acc |=> !take_valid; endproperty
    a_gap: assert property (p_gap)
        else $error("offer right after accept");
    property p_ret;
        ret_valid && !acc |=> !active[$past(ret_level)];
    endproperty
    a_ret: assert property (p_ret)
        else $error("return left level active");
    property p_mask; take_valid && take_level > 4'h2 |-> mask[take_level];
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked level offered");
    property p_above;
        take_valid |-> (active & ((16'h2 << take_level) - 16'h1)) == 16'h0;
    endproperty
    a_above: assert property (p_above)
        else $error("offer not above active level");
    property p_rst; acc && !nrs |-> ##[1:2] proc_reset; endproperty
    a_rst: assert property (p_rst)
        else $error("reset take without reset pulse");
    c_nest: cover property ($countones(active) > 1);
    c_rst: cover property (acc && !nrs);
    c_mask: cover property (pending[10] && !mask[10]);
endmodule : cep_core_checker

bind cep_core cep_core_checker u_chk (
    .ref_clk, .reset, .take_valid, .take_level, .take_ack, .save_state,
    .proc_reset, .ret_valid, .ret_level, .mask, .pending, .active
);
`default_nettype wire

// ### sim/cep_seq_model.sv
/* core sequencer model: accepts offers after a set delay and runs
   returns on request; assumes the same clock as the controller. */
`timescale 1ns/1ps
`default_nettype none
module cep_seq_model (
    input  wire logic       ref_clk,    // core clock
    input  wire logic       take_valid, // offer from controller
    input  wire logic [7:0] stall,      // cycles to wait before accept
    output var  logic       take_ack,   // accept pulse
    output var  logic       ret_valid,  // return pulse
    output var  logic [3:0] ret_level   // level returned from
);
    int n;  // cycles the current offer has waited
    // accept once the offer has stood for stall cycles
    initial begin
        take_ack = 1'b0;
        ret_valid = 1'b0;
        ret_level = 4'h0;
        n = 0;
        forever begin
            @(posedge ref_clk);
            #1;
            take_ack = 1'b0;
            if (take_valid !== 1'b1) begin
                n = 0;
            end else if (n >= stall) begin
                take_ack = 1'b1;
                n = 0;
            end else begin
                n++;
            end
        end
    end
    // one-cycle return; idle level shows the inverse
    task automatic do_ret(input logic [3:0] l);
        @(posedge ref_clk);
        #1;
        ret_valid = 1'b1;
        ret_level = l;
        @(posedge ref_clk);
        #1;
        ret_valid = 1'b0;
        ret_level = ~l;
    endtask : do_ret
endmodule : cep_seq_model
`default_nettype wire

// ### sim/tb_top.sv
/* testbench for cep_core: one task per scenario, sequencer model.
   assumes cep_map.svh on the include path. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk, reset, emu_req, core_reset_req, nmi_n;
    logic        wdog_nmi, exc_req, hw_err_req, timer_req;
    logic        take_ack, ret_valid, take_valid, save_state;
    logic        emu_mode, proc_reset;
    logic [3:0]  ret_level, take_level;
    logic [8:0]  gp_req, soft_raise;  // routed and software levels
    logic [15:0] mask, pending, active;
    logic [31:0] cur_pc, ret_addr;
    logic [7:0]  stall;               // sequencer accept delay
    int          errors, num_checks;

    cep_core dut (
        .ref_clk, .reset, .emu_req, .core_reset_req, .nmi_n, .wdog_nmi,
        .exc_req, .hw_err_req, .timer_req, .gp_req, .soft_raise, .mask,
        .cur_pc, .take_ack, .ret_valid, .ret_level, .take_valid,
        .take_level, .save_state, .emu_mode, .proc_reset, .pending,
        .active, .ret_addr
    );
    cep_seq_model seq (
        .ref_clk, .take_valid, .stall, .take_ack, .ret_valid, .ret_level
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // wait for an accepted offer and judge it; offer and ack are looked
    // at mid-cycle, where both have settled, then the accept edge passes
    task automatic take(input logic [3:0] l);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!(take_valid === 1'b1 && take_ack === 1'b1) && n < 60);
        chk(32'(n >= 60), 32'h0);
        chk(32'(take_level), 32'(l));
        @(posedge ref_clk);
        #1;
        if (l != 4'h1) chk(32'(save_state), 32'h1);
        if (l != 4'h1) chk(32'(active[l]), 32'h1);
    endtask : take
    task automatic ret(input logic [3:0] l, input logic [31:0] pc);
        seq.do_ret(l);
        chk(32'(active[l]), 32'h0);
        chk(ret_addr, pc);
    endtask : ret
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // idle after reset, then one timer event end to end
    task automatic t_walk;
        chk(32'(pending), 32'h0);
        chk(32'(active), 32'h0);
        cur_pc = 32'h0000_6000;
        timer_req = 1'b1;
        step(1);
        timer_req = 1'b0;
        take(4'h6);
        chk(32'(pending[6]), 32'h0);
        ret(4'h6, 32'h0000_6000);
    endtask : t_walk
    // three events held back, then served strictly by priority
    task automatic t_order;
        cur_pc = 32'h0000_3000;
        stall = 8'hff;
        exc_req = 1'b1;
        hw_err_req = 1'b1;
        soft_raise[2] = 1'b1;
        step(1);
        {exc_req, hw_err_req, soft_raise} = '0;
        step(5);
        chk(32'(pending & 16'h0228), 32'h0228);
        chk(32'(take_level), 32'h3);
        stall = 8'h00;
        take(4'h3);
        ret(4'h3, cur_pc);
        take(4'h5);
        ret(4'h5, cur_pc);
        take(4'h9);
        ret(4'h9, cur_pc);
    endtask : t_order
    // routed level preempted by pin nmi, then a watchdog nmi on its own
    task automatic t_nest;
        cur_pc = 32'haaaa_0000;
        gp_req[5] = 1'b1;  // router default map
        take(4'hc);
        gp_req = '0;
        cur_pc = 32'hbbbb_0000;
        nmi_n = 1'b0;
        take(4'h2);
        nmi_n = 1'b1;
        chk(32'(active), 32'h0000_1004);
        ret(4'h2, 32'hbbbb_0000);
        ret(4'hc, 32'haaaa_0000);
        wdog_nmi = 1'b1;
        step(1);
        wdog_nmi = 1'b0;
        take(4'h2);
        ret(4'h2, 32'hbbbb_0000);
    endtask : t_nest
    // a disabled level waits pending until enabled
    task automatic t_mask;
        mask = 16'hfbff;
        soft_raise[3] = 1'b1;
        step(1);
        soft_raise = '0;
        step(10);
        chk(32'(take_valid), 32'h0);
        chk(32'(pending[10]), 32'h1);
        mask = 16'hffff;
        take(4'ha);
        ret(4'ha, cur_pc);
    endtask : t_mask
    // every general level, software ones included
    task automatic t_levels;
        for (int l = 7; l < 16; l++) begin
            soft_raise[l-7] = 1'b1;
            step(1);
            soft_raise = '0;
            take(4'(l));
            ret(4'(l), cur_pc);
        end
    endtask : t_levels
    // emulation entry and exit, then the reset event
    task automatic t_special;
        emu_req = 1'b1;
        step(1);
        emu_req = 1'b0;
        take(4'h0);
        step(1);
        chk(32'(emu_mode), 32'h1);
        ret(4'h0, cur_pc);
        step(1);
        chk(32'(emu_mode), 32'h0);
        core_reset_req = 1'b1;
        step(1);
        core_reset_req = 1'b0;
        take(4'h1);
        chk(32'(proc_reset), 32'h1);
    endtask : t_special

    // clock at 4 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // cut a hang short
    initial begin
        #40000;
        errors++;
        end_of_test();
    end
    // reset, then the scenarios
    initial begin
        {emu_req, core_reset_req, wdog_nmi, exc_req} = '0;
        {hw_err_req, timer_req, gp_req, soft_raise} = '0;
        nmi_n = 1'b1;
        mask = 16'hffff;
        cur_pc = 32'h0;
        stall = 8'h00;
        errors = 0;
        num_checks = 0;
        reset = 1'b1;
        step(6);
        reset = 1'b0;
        step(2);
        t_walk();
        t_order();
        t_nest();
        t_mask();
        t_levels();
        t_special();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
